// [tpc_regs.svh]
// constants for the tag programmer command interpreter
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH
`define TPC_CLK_HZ 25000000
`define TPC_BAUD 9600
`define TPC_BIT_CYCLES (`TPC_CLK_HZ / `TPC_BAUD)
`define TPC_DATA_BITS 8
`define TPC_TIMEOUT_MS 3000
`define TPC_TIMEOUT_CYCLES (`TPC_CLK_HZ / 1000 * `TPC_TIMEOUT_MS)
`define TPC_BUF_BYTES 16
`define TPC_HEX_CHARS 32
`define TPC_FIFO_DEPTH 32
`define TPC_CH_WAKE 8'h57
`define TPC_CH_READY 8'h52
`define TPC_CH_BLANK 8'h54
`define TPC_CH_BLANK_OK 8'h59
`define TPC_CH_BLANK_BAD 8'h4e
`define TPC_CH_PROG 8'h56
`define TPC_CH_PROG_OK 8'h79
`define TPC_CH_PROG_BAD 8'h6e
`define TPC_CH_INVALID 8'h49
`endif

// [tpc_pkg.sv]
// types for the tag programmer command interpreter
package tpc_pkg;
   typedef enum logic [2:0] {
      ST_SLEEP,
      ST_IDLE,
      ST_BLANK_WAIT,
      ST_LOAD,
      ST_LOADED,
      ST_PROG_WAIT
   } tpc_state_t;
endpackage

// [tpc_fifo.sv]
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tpc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign o_in_ready = (count != (AW+1)'(DEPTH));
   assign o_out_valid = (count != '0);
   assign o_out_data = mem[rd_ptr];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   AST_NO_OVERFLOW: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

// [tpc_core.sv]
// tag programmer host command interpreter with serial link
`timescale 1ns/1ps
`default_nettype none
`include "tpc_regs.svh"
// Overview of operation
// R1: link runs 9600 baud, 8 data bits, one stop, no parity.
// R2: 57h wakes the interpreter; it answers 52h when ready.
// R3: 54h starts a contactless blank and lock check of the tag.
// R4: blank and unlocked tag answers 59h; loading may proceed.
// R5: not blank or locked answers 4Eh.
// R6: host must get a positive blank check before loading data.
// R7: host sends 16 bytes as 32 hex characters, high nibble first.
// R8: every data character accepted during loading is echoed back.
// R9: host sends hex letters only in upper case.
// R10: all 16 bytes always move; 96-bit tags ignore bits 33 to 64.
// R11: 56h after a full load programs the tag and verifies it.
// R12: matching verify answers 79h.
// R13: failed program or verify answers 6Eh.
// R14: over 3 s with no host character drops back to reset state.
// R15: non-hex character during loading reports invalid data.
// R16: program and verify takes roughly 3 to 4 s before the answer.
// R17: blank check precedes programming; each attempt ends pass or fail.
// R18: the invalid data report is the single character 49h.
// R19: after timeout or invalid report host restarts with wake-up.
// R20: program before blank check and full load, unknown commands ignored.
module tpc_core #(
   parameter int TIMEOUT_CYCLES = `TPC_TIMEOUT_CYCLES,
   parameter int BIT_CYCLES = `TPC_BIT_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire logic i_rxd,
   output logic o_txd,
   output logic o_blank_start,
   input wire logic i_blank_done,
   input wire logic i_blank_ok,
   output logic o_prog_start,
   output logic [127:0] o_prog_data,
   input wire logic i_prog_done,
   input wire logic i_prog_ok,
   output logic o_busy
);
   localparam int BIT_CYC = BIT_CYCLES;
   localparam int HALF_CYC = BIT_CYC / 2;

   // pin synchroniser
   logic rxd_meta;
   logic rxd_sync;
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rxd_meta <= 1'b1;
         rxd_sync <= 1'b1;
      end else begin
         rxd_meta <= i_rxd;
         rxd_sync <= rxd_meta;
      end
   end

   // receiver: start, 8 data lsb first, stop
   logic [12:0] rx_cnt;
   logic [3:0] rx_bit;
   logic rx_busy;
   logic [7:0] rx_shift;
   logic rx_valid;
   logic [7:0] rx_data;
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_busy <= 1'b0;
         rx_shift <= '0;
         rx_valid <= 1'b0;
         rx_data <= '0;
      end else begin
         rx_valid <= 1'b0;
         if (!rx_busy) begin
            if (!rxd_sync) begin // see R1
               rx_busy <= 1'b1;
               rx_cnt <= 13'(HALF_CYC);
               rx_bit <= '0;
            end
         end else if (rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 1'b1;
         end else begin
            rx_cnt <= 13'(BIT_CYC - 1);
            rx_bit <= rx_bit + 1'b1;
            if (rx_bit == 4'h0 && rxd_sync) begin
               rx_busy <= 1'b0; // false start
            end else if (rx_bit >= 4'h1 && rx_bit <= 4'(`TPC_DATA_BITS)) begin
               rx_shift <= {rxd_sync, rx_shift[7:1]}; // see R1
            end else if (rx_bit == 4'(`TPC_DATA_BITS + 1)) begin
               rx_busy <= 1'b0;
               if (rxd_sync) begin
                  rx_valid <= 1'b1;
                  rx_data <= rx_shift;
               end
            end
         end
      end
   end

   AST_RX_PULSE: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R1
      rx_valid |=> !rx_valid) else $error("receive strobe longer than one cycle");
   AST_RX_BAD_STOP: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R1
      rx_busy && rx_cnt == '0 && rx_bit == 4'(`TPC_DATA_BITS + 1) && !rxd_sync
      |=> !rx_valid) else $error("frame with low stop bit accepted");
   AST_RX_CNT_RANGE: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R1
      rx_busy |-> rx_cnt <= 13'(BIT_CYC - 1)) else $error("receive bit timer out of range");

   // answer path through fifo to transmitter
   logic tx_push;
   logic [7:0] tx_push_data;
   logic tx_ready_in;
   logic tx_have;
   logic [7:0] tx_head;
   logic tx_pop;
   tpc_fifo #(.WIDTH(8), .DEPTH(`TPC_FIFO_DEPTH)) u_fifo (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_in_valid(tx_push),
      .o_in_ready(tx_ready_in),
      .i_in_data(tx_push_data),
      .o_out_valid(tx_have),
      .i_out_ready(tx_pop),
      .o_out_data(tx_head)
   );

   logic [12:0] tx_cnt;
   logic [3:0] tx_bit;
   logic tx_busy;
   logic [9:0] tx_frame;
   assign tx_pop = tx_have && !tx_busy;
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_busy <= 1'b0;
         tx_frame <= '1;
         o_txd <= 1'b1;
      end else if (!tx_busy) begin
         o_txd <= 1'b1;
         if (tx_have) begin
            tx_busy <= 1'b1;
            tx_frame <= {1'b1, tx_head, 1'b0}; // see R1
            tx_cnt <= '0;
            tx_bit <= '0;
         end
      end else if (tx_cnt != '0) begin
         tx_cnt <= tx_cnt - 1'b1;
      end else if (tx_bit == 4'ha) begin
         tx_busy <= 1'b0;
      end else begin
         o_txd <= tx_frame[0];
         tx_frame <= {1'b1, tx_frame[9:1]};
         tx_bit <= tx_bit + 1'b1;
         tx_cnt <= 13'(BIT_CYC - 1);
      end
   end

   AST_TX_IDLE_HIGH: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R1
      !tx_busy |-> o_txd) else $error("line not idle high between frames");
   AST_TX_START_BIT: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R1
      $rose(tx_busy) |=> !o_txd) else $error("frame without start bit");
   AST_TX_BIT_TIME: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R1
      tx_cnt <= 13'(BIT_CYC - 1)) else $error("transmit bit timer out of range");
   AST_TX_ROOM: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R8
      tx_push |-> tx_ready_in) else $error("answer dropped at full queue");

   // hex decode of received character
   logic is_hex;
   logic [3:0] nib;
   always_comb begin
      is_hex = 1'b1;
      nib = '0;
      if (rx_data >= 8'h30 && rx_data <= 8'h39) begin
         nib = rx_data[3:0];
      end else if (rx_data >= 8'h41 && rx_data <= 8'h46) begin // see R9
         nib = 4'(rx_data[3:0] + 4'h9);
      end else begin
         is_hex = 1'b0;
      end
   end

   AST_HEX_LOWER: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R15
      rx_data >= 8'h61 && rx_data <= 8'h66 |-> !is_hex) else $error("lower case letter taken as hex");

   // command state machine
   tpc_pkg::tpc_state_t state;
   logic [5:0] nib_cnt;
   logic [31:0] idle_cnt;
   logic timeout;
   assign timeout = (idle_cnt >= 32'(TIMEOUT_CYCLES));
   assign o_busy = (state == tpc_pkg::ST_BLANK_WAIT) || (state == tpc_pkg::ST_PROG_WAIT); // see R16

   // host silence timer, held at zero while the tag operation runs
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         idle_cnt <= '0;
      end else if (rx_valid || state == tpc_pkg::ST_SLEEP || o_busy || timeout) begin
         idle_cnt <= '0; // see R14
      end else begin
         idle_cnt <= idle_cnt + 1'b1;
      end
   end

   AST_TIMER_LIMIT: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R14
      idle_cnt <= 32'(TIMEOUT_CYCLES)) else $error("silence timer ran past its limit");
   AST_TIMER_FROZEN: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R16
      o_busy |-> idle_cnt == '0) else $error("silence timer ran during tag operation");
   AST_TIMER_HOST: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R14
      rx_valid |=> idle_cnt == '0) else $error("host character did not restart timer");

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= tpc_pkg::ST_SLEEP;
         nib_cnt <= '0;
         o_prog_data <= '0;
         o_blank_start <= 1'b0;
         o_prog_start <= 1'b0;
         tx_push <= 1'b0;
         tx_push_data <= '0;
      end else begin
         o_blank_start <= 1'b0;
         o_prog_start <= 1'b0;
         tx_push <= 1'b0;
         if (timeout) begin
            state <= tpc_pkg::ST_SLEEP; // see R14
         end else begin
            case (state)
               tpc_pkg::ST_SLEEP: begin
                  if (rx_valid && rx_data == `TPC_CH_WAKE) begin
                     state <= tpc_pkg::ST_IDLE; // see R2
                     tx_push <= 1'b1;
                     tx_push_data <= `TPC_CH_READY;
                  end
               end
               tpc_pkg::ST_IDLE, tpc_pkg::ST_LOADED: begin
                  if (rx_valid && rx_data == `TPC_CH_BLANK) begin
                     state <= tpc_pkg::ST_BLANK_WAIT; // see R3
                     o_blank_start <= 1'b1;
                  end else if (rx_valid && rx_data == `TPC_CH_PROG && state == tpc_pkg::ST_LOADED) begin
                     state <= tpc_pkg::ST_PROG_WAIT; // see R11
                     o_prog_start <= 1'b1;
                  end
                  // other characters ignored, see R20
               end
               tpc_pkg::ST_BLANK_WAIT: begin
                  if (i_blank_done) begin
                     tx_push <= 1'b1;
                     nib_cnt <= '0;
                     if (i_blank_ok) begin
                        tx_push_data <= `TPC_CH_BLANK_OK; // see R4
                        state <= tpc_pkg::ST_LOAD;
                     end else begin
                        tx_push_data <= `TPC_CH_BLANK_BAD; // see R5
                        state <= tpc_pkg::ST_IDLE;
                     end
                  end
               end
               tpc_pkg::ST_LOAD: begin
                  if (rx_valid) begin
                     tx_push <= 1'b1;
                     if (is_hex) begin
                        tx_push_data <= rx_data; // see R8
                        o_prog_data <= {o_prog_data[123:0], nib}; // see R10
                        nib_cnt <= nib_cnt + 1'b1;
                        if (nib_cnt == 6'(`TPC_HEX_CHARS - 1)) begin
                           state <= tpc_pkg::ST_LOADED;
                        end
                     end else begin
                        tx_push_data <= `TPC_CH_INVALID; // see R15 R18
                        state <= tpc_pkg::ST_SLEEP;
                     end
                  end
               end
               tpc_pkg::ST_PROG_WAIT: begin
                  if (i_prog_done) begin
                     tx_push <= 1'b1; // see R17
                     tx_push_data <= i_prog_ok ? `TPC_CH_PROG_OK : `TPC_CH_PROG_BAD; // see R12 R13
                     state <= tpc_pkg::ST_IDLE;
                  end
               end
               default: begin
                  state <= tpc_pkg::ST_SLEEP;
               end
            endcase
         end
      end
   end

   AST_WAKE_ANSWER: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R2
      state == tpc_pkg::ST_SLEEP && rx_valid && rx_data == `TPC_CH_WAKE && !timeout
      |=> tx_push && tx_push_data == `TPC_CH_READY) else $error("wake not answered");
   AST_BLANK_START: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R3
      o_blank_start |-> state == tpc_pkg::ST_BLANK_WAIT) else $error("blank start misplaced");
   AST_BLANK_OK: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R4
      state == tpc_pkg::ST_BLANK_WAIT && i_blank_done && i_blank_ok && !timeout
      |=> tx_push_data == `TPC_CH_BLANK_OK && state == tpc_pkg::ST_LOAD) else $error("blank pass wrong");
   AST_BLANK_BAD: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R5
      state == tpc_pkg::ST_BLANK_WAIT && i_blank_done && !i_blank_ok && !timeout
      |=> tx_push_data == `TPC_CH_BLANK_BAD) else $error("blank fail wrong");
   AST_ECHO: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R8
      state == tpc_pkg::ST_LOAD && rx_valid && is_hex && !timeout
      |=> tx_push && tx_push_data == $past(rx_data)) else $error("no echo");
   AST_INVALID: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R18
      state == tpc_pkg::ST_LOAD && rx_valid && !is_hex && !timeout
      |=> tx_push_data == `TPC_CH_INVALID && state == tpc_pkg::ST_SLEEP) else $error("invalid not sent");
   AST_PROG_GATED: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R20
      o_prog_start |-> $past(state) == tpc_pkg::ST_LOADED) else $error("program without load");
   AST_PROG_RESULT: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R12
      state == tpc_pkg::ST_PROG_WAIT && i_prog_done && !timeout
      |=> tx_push && tx_push_data == ($past(i_prog_ok) ? `TPC_CH_PROG_OK : `TPC_CH_PROG_BAD))
      else $error("program result wrong");
   AST_TIMEOUT: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R14
      timeout |=> state == tpc_pkg::ST_SLEEP) else $error("timeout ignored");
   AST_BLANK_PULSE: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R3
      o_blank_start |=> !o_blank_start) else $error("blank start longer than one cycle");
   AST_PROG_PULSE: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R11
      o_prog_start |=> !o_prog_start) else $error("program start longer than one cycle");
   AST_PROG_HELD: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R11
      o_busy |=> $stable(o_prog_data)) else $error("buffer changed during tag operation");
   AST_PROG_FAIL: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R13
      state == tpc_pkg::ST_PROG_WAIT && i_prog_done && !i_prog_ok && !timeout
      |=> tx_push && tx_push_data == `TPC_CH_PROG_BAD) else $error("program failure not reported");
   AST_PROG_FULL: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R17
      o_prog_start |-> nib_cnt == 6'(`TPC_HEX_CHARS)) else $error("program started without full load");
   AST_LOADED_FULL: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R11
      state == tpc_pkg::ST_LOADED |-> nib_cnt == 6'(`TPC_HEX_CHARS)) else $error("loaded with short buffer");
   AST_LOAD_END: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R10
      state == tpc_pkg::ST_LOAD && rx_valid && is_hex && nib_cnt == 6'(`TPC_HEX_CHARS - 1) && !timeout
      |=> state == tpc_pkg::ST_LOADED) else $error("load did not end after last digit");
   AST_LOAD_SHIFT: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R10
      state == tpc_pkg::ST_LOAD && rx_valid && is_hex && !timeout
      |=> o_prog_data == {$past(o_prog_data[123:0]), $past(nib)}) else $error("buffer shift wrong");
   AST_IDLE_IGNORE: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R20
      state == tpc_pkg::ST_IDLE && rx_valid && rx_data != `TPC_CH_BLANK && !timeout
      |=> state == tpc_pkg::ST_IDLE && !tx_push) else $error("unknown command acted on");
   AST_SLEEP_SILENT: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // see R2
      state == tpc_pkg::ST_SLEEP && !(rx_valid && rx_data == `TPC_CH_WAKE)
      |=> !tx_push && state == tpc_pkg::ST_SLEEP) else $error("sleeping interpreter answered");
endmodule
`default_nettype wire

// [tpc_host_model.sv]
// host side serial model for the tag programmer link
`timescale 1ns/1ps
`default_nettype none
module tpc_host_model #(
   parameter int BIT_CYC = 2604
) (
   input wire logic i_mclk,
   input wire logic i_txd,
   output logic o_rxd
);
   logic [7:0] rxq[$];
   logic [7:0] sh;
   initial o_rxd = 1'b1;
   // start, 8 bits lsb first, one stop, no parity
   task automatic send_char(input logic [7:0] c);
      logic [9:0] fr;
      fr = {1'b1, c, 1'b0};
      for (int b = 0; b < 10; b++) begin
         @(negedge i_mclk);
         o_rxd = fr[b];
         repeat (BIT_CYC - 1) @(negedge i_mclk);
      end
   endtask
   // mid-bit sampling, frames with a bad stop bit dropped
   initial begin
      forever begin
         @(negedge i_txd);
         repeat (BIT_CYC / 2) @(posedge i_mclk);
         if (i_txd === 1'b0) begin
            for (int b = 0; b < 8; b++) begin
               repeat (BIT_CYC) @(posedge i_mclk);
               sh = {i_txd, sh[7:1]};
            end
            repeat (BIT_CYC) @(posedge i_mclk);
            if (i_txd === 1'b1) rxq.push_back(sh);
         end
      end
   end
endmodule
`default_nettype wire

// [tag_programmer_host_protocol_test.sv]
// self-checking bench for the tag programmer interpreter
`timescale 1ns/1ps
`default_nettype none
`include "tpc_regs.svh"
module tag_programmer_host_protocol_test;
   // short bit time and timeout keep the run brief
   localparam int TO = 2000;
   localparam int BC = 16;
   localparam logic [127:0] D1 = 128'hf1e2d3c4b5a6978888796a5b4c3d2e1f;
   localparam logic [127:0] D2 = 128'h0123456789abcdef0fedcba987654321;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic rxd, txd, bst, pst, busy, kind, bsy_seen;
   logic bdone = 1'b0;
   logic bok = 1'b0;
   logic pdone = 1'b0;
   logic pok = 1'b0;
   logic bres = 1'b0;
   logic pres = 1'b0;
   logic [127:0] pdata, pcap;
   int err_total = 0;
   int total_checks = 0;
   int nb = 0;
   int np = 0;
   always #20 mclk = ~mclk;
   tpc_core #(.TIMEOUT_CYCLES(TO), .BIT_CYCLES(BC)) u_dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_rxd(rxd), .o_txd(txd),
      .o_blank_start(bst), .i_blank_done(bdone), .i_blank_ok(bok), .o_prog_start(pst),
      .o_prog_data(pdata), .i_prog_done(pdone), .i_prog_ok(pok), .o_busy(busy));
   tpc_host_model #(.BIT_CYC(BC)) u_host (.i_mclk(mclk), .i_txd(txd), .o_rxd(rxd));
   // tag side: answers each start after a pause
   initial begin
      forever begin
         @(negedge mclk);
         if (bst === 1'b1 || pst === 1'b1) begin
            kind = pst;
            nb += int'(bst);
            np += int'(pst);
            pcap = pdata;
            repeat (40) @(negedge mclk);
            bsy_seen = busy;
            bok = bres;
            pok = pres;
            if (kind) pdone = 1'b1;
            else bdone = 1'b1;
            @(negedge mclk);
            bdone = 1'b0;
            pdone = 1'b0;
         end
      end
   end
   task automatic stop_test();
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [7:0] c, input logic [7:0] exp);
      int n;
      n = 0;
      u_host.send_char(c);
      while (u_host.rxq.size() == 0 && n < 40 * BC) begin
         @(posedge mclk);
         n++;
      end
      if (u_host.rxq.size() == 0) begin
         chk(9'h100, exp);
         stop_test();
      end
      else chk(u_host.rxq.pop_front(), exp);
   endtask
   task automatic quiet(input logic [7:0] c);
      u_host.send_char(c);
      repeat (12 * BC) @(posedge mclk);
      chk(u_host.rxq.size(), 0);
   endtask
   function automatic logic [7:0] hexc(input logic [3:0] v);
      return (v < 4'ha) ? 8'h30 + v : 8'h37 + v;
   endfunction
   // 32 upper-case digits, high nibble first
   task automatic load(input logic [127:0] d);
      logic [7:0] c;
      for (int i = 31; i >= 0; i--) begin
         c = hexc(d[i*4 +: 4]);
         xfer(c, c);
      end
   endtask
   task automatic t_wake();
      chk(txd, 1'b1);
      quiet(8'h54);
      chk(nb, 0);
      xfer(8'h57, 8'h52);
      quiet(8'h56);
      chk(np, 0);
   endtask
   task automatic t_blank_bad();
      bres = 1'b0;
      xfer(8'h54, 8'h4e);
      chk(bsy_seen, 1'b1);
      chk(nb, 1);
   endtask
   task automatic t_prog();
      bres = 1'b1;
      pres = 1'b1;
      xfer(8'h54, 8'h59);
      load(D1);
      xfer(8'h56, 8'h79);
      chk(pcap, D1);
      xfer(8'h54, 8'h59);
      load(D2);
      pres = 1'b0;
      xfer(8'h56, 8'h6e);
      chk(pcap, D2);
      chk(np, 2);
   endtask
   task automatic t_invalid();
      xfer(8'h54, 8'h59);
      xfer(8'h30, 8'h30);
      xfer(8'h61, 8'h49);
      xfer(8'h57, 8'h52);
   endtask
   task automatic t_timeout();
      repeat (TO + 1000) @(posedge mclk);
      quiet(8'h54);
      xfer(8'h57, 8'h52);
   endtask
   initial begin
      repeat (6) @(negedge mclk);
      arst_n = 1'b1;
      repeat (4) @(negedge mclk);
      t_wake();
      t_blank_bad();
      t_prog();
      t_invalid();
      t_timeout();
      stop_test();
   end
endmodule
`default_nettype wire
